// [inc/sarcs_defines.svh]
`ifndef SARCS_DEFINES_SVH
`define SARCS_DEFINES_SVH
// register offsets
`define SARCS_ADDR_CSB      8'h03
`define SARCS_ADDR_RES_LO   8'h04
`define SARCS_ADDR_RES_HI   8'h05
`define SARCS_ADDR_CSA      8'h06
`define SARCS_ADDR_SEL      8'h07
// control_status_a fields
`define SARCS_CSA_EN        7
`define SARCS_CSA_START     6
`define SARCS_CSA_AUTO      5
`define SARCS_CSA_DONE      4
`define SARCS_CSA_IE        3
// input_selection_register fields
`define SARCS_SEL_REF_HI    7
`define SARCS_SEL_REF_MID   6
`define SARCS_SEL_LADJ      5
`define SARCS_SEL_REF_LO    4
// reset values
`define SARCS_RST_CSA       8'h00
`define SARCS_RST_SEL       8'h00
`define SARCS_RST_TSEL      3'h0
// channel codes
`define SARCS_CH_TEMP       4'hF
`define SARCS_CH_DIFF_FIRST 4'h4
`define SARCS_CH_DIFF_20X   2'h1
// timing in half converter clock cycles
`define SARCS_HC_NORM_DONE  6'h1A
`define SARCS_HC_NORM_SH    6'h03
`define SARCS_HC_FIRST_DONE 6'h32
`define SARCS_HC_FIRST_SH   6'h1B
`define SARCS_HC_AUTO_DONE  6'h1B
`define SARCS_HC_AUTO_SH    6'h04
// trigger source code meaning free running
`define SARCS_TSEL_FREE     3'h0
// cpu cycles of trigger synchronisation
`define SARCS_TRIG_SYNC     3
`endif

// [inc/sarcs_pkg.sv]
package sarcs_pkg;
   typedef enum logic [1:0] {
      SARCS_IDLE,
      SARCS_WAIT,
      SARCS_CONV
   } sarcs_state_e;
   typedef logic [9:0] sarcs_result_t;
endpackage

// [rtl/sarcs_sequencer.sv]
// Chosen here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`include "sarcs_defines.svh"
// Summary of operation
// - ten-bit result, zero is ground
// - differential gain 1x/20x, single-ended bypassed
// - channel 1111 selects temperature sensor
// - selections apply only while enabled
// - right-justified result, left when adjusted
// - low read locks, high read unlocks
// - locked completion drops result, flags done
// - start bit held until single completion
// - channel change waits for conversion end
// - trigger edge resets prescaler, starts conversion
// - busy edges and held trigger ignored
// - source flags need software clear
// - done-flag trigger runs back to back
// - start reads one while busy, starts only if idle and already enabled
// - prescaler divides, held reset when disabled
// - software start on next converter edge
// - thirteen cycles, first conversion twenty-five
// - sample at 1.5, first at 13.5
// - result, done flag, start clear together
// - auto: sample at 2, total 13.5
// - free running restarts, start stays set
// - selections latched, reopen in last cycle
// - trigger select bits 2:0 at 0x03
module sarcs_sequencer
   import sarcs_pkg::*;
#(
   parameter int PRESC_W = 7
)
(
   // clock and reset
   input  wire logic       i_clk_sys,
   input  wire logic       i_rst,
   // register port
   input  wire logic [7:0] i_addr,
   input  wire logic [7:0] i_wdata,
   input  wire logic       i_wr,
   input  wire logic       i_rd,
   output logic      [7:0] o_rdata,
   // trigger sources, same clock
   input  wire logic [7:0] i_trig_src,
   // abstract analog value at converter input
   input  wire logic [9:0] i_analog_level,
   // analog front end control
   output logic      [2:0] o_reference_select,
   output logic      [3:0] o_channel_select,
   output logic            o_gain_20x,
   output logic            o_gain_bypass,
   output logic            o_temp_sensor_sel,
   output logic            o_sample_hold,
   // status
   output logic            o_busy,
   output logic            o_conv_done_irq
);
   // software registers
   logic [7:0]    csa_q;
   logic [7:0]    sel_q;
   logic [2:0]    tsel_q;
   logic          pend_q;
   logic          lock_q;
   sarcs_result_t res_q;
   // conversion engine
   sarcs_state_e  st_q;
   logic [5:0]    hc_q;
   logic          first_q;
   logic          auto_q;
   logic          en_q;
   logic [PRESC_W-1:0] psc_q;
   logic [`SARCS_TRIG_SYNC-1:0] tpipe_q;
   logic          trig_q;
   sarcs_result_t held_q;
   logic [9:0]    an_m_q;
   logic [9:0]    an_s_q;
   logic [7:0]    front_q;
   logic          sh_q;

   // bus decode
   wire logic en       = csa_q[`SARCS_CSA_EN];
   wire logic wr_csa   = i_wr && (i_addr == `SARCS_ADDR_CSA);
   wire logic wr_sel   = i_wr && (i_addr == `SARCS_ADDR_SEL);
   wire logic wr_csb   = i_wr && (i_addr == `SARCS_ADDR_CSB);
   wire logic rd_lo    = i_rd && (i_addr == `SARCS_ADDR_RES_LO);
   wire logic rd_hi    = i_rd && (i_addr == `SARCS_ADDR_RES_HI);
   wire logic sw_start = wr_csa && i_wdata[`SARCS_CSA_START]
                         && i_wdata[`SARCS_CSA_EN];
   wire logic done_clr = wr_csa && i_wdata[`SARCS_CSA_DONE];
   wire logic ladj     = sel_q[`SARCS_SEL_LADJ];

   // prescaler masks: select 0 and 1 both divide by two
   wire logic [2:0]         ps   = csa_q[2:0];
   wire logic [PRESC_W-1:0] mask = (ps == 3'h0) ? PRESC_W'(1)
                                   : PRESC_W'((8'h01 << ps) - 8'h01);
   wire logic [PRESC_W-1:0] low  = psc_q & mask;
   wire logic tick     = en && (low == mask);
   wire logic mid      = en && (low == (mask >> 1));
   wire logic half     = tick || mid;

   // trigger edge selection
   wire logic free_run = csa_q[`SARCS_CSA_AUTO] && (tsel_q == `SARCS_TSEL_FREE);
   wire logic trig_lvl = i_trig_src[tsel_q];
   wire logic trig_edg = en && csa_q[`SARCS_CSA_AUTO] && !free_run
                         && trig_lvl && !trig_q && (st_q == SARCS_IDLE);
   wire logic trig_go  = tpipe_q[`SARCS_TRIG_SYNC-1];

   // timing per conversion kind
   wire logic [5:0] hc_done = first_q ? `SARCS_HC_FIRST_DONE
                              : auto_q ? `SARCS_HC_AUTO_DONE
                              : `SARCS_HC_NORM_DONE;
   wire logic [5:0] hc_sh   = first_q ? `SARCS_HC_FIRST_SH
                              : auto_q ? `SARCS_HC_AUTO_SH
                              : `SARCS_HC_NORM_SH;
   wire logic converting = (st_q == SARCS_CONV);
   wire logic finish   = converting && half && (hc_q == hc_done - 6'h01);
   wire logic sample   = converting && half && (hc_q == hc_sh - 6'h01);
   wire logic sel_open = !converting || (hc_q >= hc_done - 6'h02);
   wire logic restart  = finish && free_run;

   // start bit reads one while busy
   wire logic start_rd = pend_q || (st_q != SARCS_IDLE) || trig_go;
   wire logic [7:0] csa_rd = {csa_q[7], start_rd, csa_q[5:0]};
   wire logic [7:0] lo_rd  = ladj ? {res_q[1:0], 6'h00} : res_q[7:0];
   wire logic [7:0] hi_rd  = ladj ? res_q[9:2] : {6'h00, res_q[9:8]};
   wire logic [7:0] rd_mux = (i_addr == `SARCS_ADDR_CSA)    ? csa_rd
                           : (i_addr == `SARCS_ADDR_SEL)    ? sel_q
                           : (i_addr == `SARCS_ADDR_CSB)    ? {5'h00, tsel_q}
                           : (i_addr == `SARCS_ADDR_RES_LO) ? lo_rd
                           : (i_addr == `SARCS_ADDR_RES_HI) ? hi_rd
                           : 8'h00;

   // front end decode from the latched selection
   wire logic [3:0] ch = front_q[3:0];
   wire logic diff     = (ch >= `SARCS_CH_DIFF_FIRST) && (ch != `SARCS_CH_TEMP);
   assign o_gain_bypass      = !diff;
   assign o_gain_20x         = diff && (ch[1:0] == `SARCS_CH_DIFF_20X);
   assign o_temp_sensor_sel  = (ch == `SARCS_CH_TEMP);
   assign o_channel_select   = ch;
   assign o_reference_select = front_q[6:4];
   assign o_sample_hold      = sh_q;
   assign o_busy             = converting;
   assign o_conv_done_irq    = csa_q[`SARCS_CSA_DONE] && csa_q[`SARCS_CSA_IE];

   // read data, one cycle after the strobe
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
         o_rdata <= 8'h00;
      else
         o_rdata <= i_rd ? rd_mux : 8'h00;
   end

   // control_status_a: enable, auto, done flag, ie, prescale
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
         csa_q <= `SARCS_RST_CSA;
      else
      begin
         if (wr_csa)
         begin
            csa_q[7]   <= i_wdata[7];
            csa_q[5]   <= i_wdata[5];
            csa_q[3:0] <= i_wdata[3:0];
         end
         csa_q[`SARCS_CSA_START] <= 1'b0; // start state lives in pend_q/st_q
         // done flag set wins over clear
         if (finish)
            csa_q[`SARCS_CSA_DONE] <= 1'b1;
         else if (done_clr)
            csa_q[`SARCS_CSA_DONE] <= 1'b0;
      end
   end

   // selection and trigger select registers
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         sel_q  <= `SARCS_RST_SEL;
         tsel_q <= `SARCS_RST_TSEL;
      end
      else
      begin
         if (wr_sel)
            sel_q <= i_wdata;
         if (wr_csb)
            tsel_q <= i_wdata[2:0];
      end
   end

   // front end follows register only while enabled
   // held until the running conversion ends
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
         front_q <= 8'h00;
      else if (!en)
         front_q <= 8'h00;
      else if (sel_open)
         front_q <= {1'b0, sel_q[`SARCS_SEL_REF_HI], sel_q[`SARCS_SEL_REF_MID],
                     sel_q[`SARCS_SEL_REF_LO], sel_q[3:0]};
   end

   // prescaler, held in reset when disabled
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
         psc_q <= '0;
      else if (!en || trig_go)
         psc_q <= '0;
      else
         psc_q <= psc_q + PRESC_W'(1);
   end

   // trigger history and synchronisation pipe
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         trig_q  <= 1'b0;
         tpipe_q <= '0;
      end
      else
      begin
         trig_q  <= trig_lvl;
         tpipe_q <= {tpipe_q[`SARCS_TRIG_SYNC-2:0], trig_edg};
      end
   end

   // enable history marks the first conversion
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         en_q    <= 1'b0;
         first_q <= 1'b0;
      end
      else
      begin
         en_q <= en;
         if (en && !en_q)
            first_q <= 1'b1;
         else if (finish || !en)
            first_q <= finish ? 1'b0 : first_q;
      end
   end

   // conversion sequencer
   // source flag cleared by software, not here
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         st_q   <= SARCS_IDLE;
         hc_q   <= 6'h00;
         pend_q <= 1'b0;
         auto_q <= 1'b0;
      end
      else if (!en)
      begin
         st_q   <= SARCS_IDLE;
         hc_q   <= 6'h00;
         pend_q <= 1'b0;
      end
      else
      begin
         case (st_q)
            SARCS_IDLE:
            begin
               hc_q <= 6'h00;
               if (trig_go)
               begin
                  st_q   <= SARCS_CONV;
                  auto_q <= 1'b1;
               end
               // software start even in auto mode
               else if (sw_start)
               begin
                  st_q   <= SARCS_WAIT;
                  pend_q <= 1'b1;
               end
            end
            SARCS_WAIT:
            begin
               // begin at next converter clock edge
               if (tick)
               begin
                  st_q   <= SARCS_CONV;
                  auto_q <= 1'b0;
                  pend_q <= 1'b0;
               end
            end
            SARCS_CONV:
            begin
               if (half)
                  hc_q <= hc_q + 6'h01;
               // back to back regardless of flag
               if (restart)
               begin
                  hc_q   <= 6'h00;
                  auto_q <= 1'b0;
               end
               // single mode ends, start bit drops
               else if (finish)
                  st_q <= SARCS_IDLE;
            end
            default:
               st_q <= SARCS_IDLE;
         endcase
      end
   end

   // analog level synchroniser, two stages
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         an_m_q <= 10'h000;
         an_s_q <= 10'h000;
      end
      else
      begin
         an_m_q <= i_analog_level;
         an_s_q <= an_m_q;
      end
   end

   // sampler holds value from the sample instant
   // code zero is ground, full scale is reference
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         held_q <= 10'h000;
         sh_q   <= 1'b0;
      end
      else
      begin
         sh_q <= sample;
         if (sample)
            held_q <= an_s_q;
      end
   end

   // result registers and read lock
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         res_q  <= 10'h000;
         lock_q <= 1'b0;
      end
      else
      begin
         // result written with the done flag
         if (finish && !lock_q)
            res_q <= held_q;
         // low read locks, high read releases
         if (rd_lo)
            lock_q <= 1'b1;
         else if (rd_hi)
            lock_q <= 1'b0;
      end
   end
endmodule

// [sim/sarcs_source_model.sv]
`timescale 1ns/1ps
module sarcs_source_model
(
   // clock
   input  wire logic       i_clk_sys,
   // bench commands
   input  wire logic [2:0] i_fire_idx,
   input  wire logic       i_fire,
   input  wire logic       i_clear,
   input  wire logic [9:0] i_level,
   // toward the sequencer
   output logic      [7:0] o_trig_src = 8'h00,
   output logic      [9:0] o_analog_level
);
   always @(posedge i_clk_sys)
   begin
      if (i_clear)
         o_trig_src <= 8'h00;
      else if (i_fire)
         o_trig_src[i_fire_idx] <= 1'b1;
   end
   assign o_analog_level = i_level;
endmodule

// [sim/sarcs_sequencer_assertions.sv]
`timescale 1ns/1ps
module sarcs_sequencer_assertions
#(
   parameter int PRESC_W = 7
)
(
   // clock, reset, bus
   input wire logic       i_clk_sys,
   input wire logic       i_rst,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic       i_wr,
   input wire logic       i_rd,
   input wire logic [7:0] o_rdata,
   // sources and front end
   input wire logic [7:0] i_trig_src,
   input wire logic [9:0] i_analog_level,
   input wire logic [2:0] o_reference_select,
   input wire logic [3:0] o_channel_select,
   input wire logic       o_gain_20x,
   input wire logic       o_gain_bypass,
   input wire logic       o_temp_sensor_sel,
   input wire logic       o_sample_hold,
   input wire logic       o_busy,
   input wire logic       o_conv_done_irq
);
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (i_rst);
   // read data only right after a read
   a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
      else $error("read data outside answer cycle");
   a_unmapped_zero: assert property ($past(i_rd) && ($past(i_addr) < 8'h03 ||
      $past(i_addr) > 8'h07) |-> o_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_csb_upper: assert property ($past(i_rd) && $past(i_addr) == 8'h03
      |-> o_rdata[7:3] == 5'h00)
      else $error("trigger register upper bits set");
   // front end decode
   a_temp_decode: assert property (o_temp_sensor_sel == (o_channel_select == 4'hF))
      else $error("temperature select mismatch");
   a_gain_high: assert property (o_gain_20x |-> o_channel_select inside {[4'h4:4'hE]}
      && o_channel_select[1:0] == 2'h1)
      else $error("high gain on wrong channel");
   a_gain_bypass: assert property (o_gain_bypass |-> !o_gain_20x &&
      (o_channel_select < 4'h4 || o_channel_select == 4'hF))
      else $error("bypass on differential channel");
   // timing of conversion events
   a_sample_busy: assert property (o_sample_hold |-> $past(o_busy))
      else $error("sample outside conversion");
   a_chan_locked: assert property ($rose(o_busy) |=>
      (!o_busy || $stable(o_channel_select))[*8])
      else $error("channel moved during conversion");
   a_irq_finish: assert property ($rose(o_conv_done_irq) |-> $past(o_busy))
      else $error("done flag without conversion");
   cover property ($rose(o_busy));
   cover property ($rose(o_conv_done_irq));
   cover property (o_sample_hold);
endmodule
bind sarcs_sequencer sarcs_sequencer_assertions #(.PRESC_W(PRESC_W)) i_chk
(
   .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
   .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_trig_src(i_trig_src),
   .i_analog_level(i_analog_level), .o_reference_select(o_reference_select),
   .o_channel_select(o_channel_select), .o_gain_20x(o_gain_20x),
   .o_gain_bypass(o_gain_bypass), .o_temp_sensor_sel(o_temp_sensor_sel),
   .o_sample_hold(o_sample_hold), .o_busy(o_busy), .o_conv_done_irq(o_conv_done_irq)
);

// [sim/sarcs_sequencer_test.sv]
`timescale 1ns/1ps
`include "sarcs_defines.svh"
module sarcs_sequencer_test;
   logic       i_clk_sys = 1'b0;
   logic       i_rst     = 1'b1;
   logic [7:0] i_addr    = 8'h00;
   logic [7:0] i_wdata   = 8'h00;
   logic       i_wr      = 1'b0;
   logic       i_rd      = 1'b0;
   logic       fire      = 1'b0;
   logic       clr       = 1'b0;
   logic [9:0] lvl       = 10'h2A5;
   logic [7:0] trig;
   logic [9:0] alvl;
   logic [7:0] o_rdata;
   logic [2:0] ref_sel;
   logic [3:0] ch;
   logic       g20;
   logic       byp;
   logic       temp;
   logic       busy;
   logic       irq;
   int         err_count = 0;
   int         compares  = 0;
   // half period of 2.5 ns
   always #2.5 i_clk_sys = ~i_clk_sys;
   sarcs_source_model i_src (.i_clk_sys(i_clk_sys), .i_fire_idx(3'h3), .i_fire(fire),
      .i_clear(clr), .i_level(lvl), .o_trig_src(trig), .o_analog_level(alvl));
   sarcs_sequencer i_dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_trig_src(trig),
      .i_analog_level(alvl), .o_reference_select(ref_sel), .o_channel_select(ch),
      .o_gain_20x(g20), .o_gain_bypass(byp), .o_temp_sensor_sel(temp),
      .o_sample_hold(), .o_busy(busy), .o_conv_done_irq(irq));
   task automatic chk(input logic [9:0] got, input logic [9:0] exp);
      compares++;
      if (got !== exp)
      begin
         err_count++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk_sys);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk_sys);
      i_wr <= 1'b0;
   endtask
   // data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge i_clk_sys);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk_sys);
      i_rd <= 1'b0;
      #1;
      chk({2'h0, o_rdata}, {2'h0, e});
   endtask
   // bounded waits, then busy length in cpu cycles
   task automatic run_conv(input logic [9:0] e);
      int n;
      n = 0;
      while (busy !== 1'b1 && n < 200)
      begin
         @(posedge i_clk_sys);
         #1;
         n++;
      end
      n = 0;
      while (busy === 1'b1 && n < 200)
      begin
         @(posedge i_clk_sys);
         #1;
         n++;
      end
      chk(n[9:0], e);
   endtask
   // one edge of a source command
   task automatic pulse(input logic c);
      @(posedge i_clk_sys);
      clr <= c;
      fire <= !c;
      @(posedge i_clk_sys);
      clr <= 1'b0;
      fire <= 1'b0;
   endtask
   task automatic give_verdict;
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // watchdog, tests need about 400 cycles
   initial
   begin
      #(20000 * 5);
      err_count++;
      give_verdict();
   end
   initial
   begin
      repeat (3) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      rd(`SARCS_ADDR_CSA, 8'h00);
      wr(`SARCS_ADDR_CSB, 8'hFF);
      rd(`SARCS_ADDR_CSB, 8'h07);
      rd(8'h10, 8'h00);
      wr(`SARCS_ADDR_CSB, 8'h00);
      wr(`SARCS_ADDR_SEL, 8'hC5);
      #1 chk({6'h0, ch}, 10'h000);
      wr(`SARCS_ADDR_CSA, 8'h88);
      repeat (2) @(posedge i_clk_sys);
      #1 chk({7'h0, ref_sel}, 10'h006);
      chk({8'h0, g20, byp}, 10'h002);
      $display("select test done");
      wr(`SARCS_ADDR_CSA, 8'hC8);
      fork
         run_conv(10'd50);
         rd(`SARCS_ADDR_CSA, 8'hC8);
      join
      rd(`SARCS_ADDR_CSA, 8'h98);
      rd(`SARCS_ADDR_RES_LO, 8'hA5);
      rd(`SARCS_ADDR_RES_HI, 8'h02);
      rd(`SARCS_ADDR_RES_LO, 8'hA5);
      @(posedge i_clk_sys);
      lvl <= 10'h155;
      wr(`SARCS_ADDR_CSA, 8'hD8);
      fork
         run_conv(10'd26);
         begin
            repeat (6) @(posedge i_clk_sys);
            wr(`SARCS_ADDR_SEL, 8'hC2);
            #1 chk({6'h0, ch}, 10'h005);
         end
      join
      repeat (2) @(posedge i_clk_sys);
      #1 chk({6'h0, ch}, 10'h002);
      chk({9'h0, irq}, 10'h001);
      rd(`SARCS_ADDR_RES_LO, 8'hA5);
      rd(`SARCS_ADDR_RES_HI, 8'h02);
      wr(`SARCS_ADDR_SEL, 8'hE5);
      wr(`SARCS_ADDR_CSA, 8'hD8);
      run_conv(10'd26);
      rd(`SARCS_ADDR_RES_LO, 8'h40);
      rd(`SARCS_ADDR_RES_HI, 8'h55);
      wr(`SARCS_ADDR_SEL, 8'hCF);
      repeat (2) @(posedge i_clk_sys);
      #1 chk({8'h0, temp, byp}, 10'h003);
      $display("single test done");
      wr(`SARCS_ADDR_CSB, 8'h03);
      wr(`SARCS_ADDR_CSA, 8'hB8);
      pulse(1'b0);
      run_conv(10'd27);
      repeat (40) @(posedge i_clk_sys);
      #1 chk({9'h0, busy}, 10'h000);
      pulse(1'b1);
      pulse(1'b0);
      run_conv(10'd27);
      $display("trigger test done");
      wr(`SARCS_ADDR_CSB, 8'h00);
      wr(`SARCS_ADDR_CSA, 8'hF8);
      repeat (120) @(posedge i_clk_sys);
      #1 chk({9'h0, busy}, 10'h001);
      rd(`SARCS_ADDR_CSA, 8'hF8);
      wr(`SARCS_ADDR_CSA, 8'h00);
      repeat (2) @(posedge i_clk_sys);
      #1 chk({5'h0, busy, ch}, 10'h000);
      $display("free running test done");
      give_verdict();
   end
endmodule
